// >>> sled_pkg.sv
package sled_pkg;
    localparam int SLED_DW = 16;
    localparam int SLED_AW = 3;
    localparam int SLED_SW = 8;
    localparam int SLED_NSTK = 2;

    // Register addresses on the plain register port
    localparam logic [2:0] SLED_OFS_PTR  = 3'h0;
    localparam logic [2:0] SLED_OFS_OVF  = 3'h1;
    localparam logic [2:0] SLED_OFS_UNF  = 3'h2;
    localparam logic [2:0] SLED_OFS_IBC  = 3'h3;
    localparam logic [2:0] SLED_OFS_STAT = 3'h4;
    localparam logic [2:0] SLED_OFS_MASK = 3'h5;

    localparam logic [15:0] SLED_RST_PTR = 16'h0000;
    localparam logic [15:0] SLED_RST_OVF = 16'h0000;
    localparam logic [15:0] SLED_RST_UNF = 16'h0000;
    localparam logic [10:0] SLED_RST_IBC = 11'h000;
    localparam logic [3:0]  SLED_RST_MSK = 4'h0;

    // Fields inside one stack byte of the underflow-limit register
    localparam int SLED_SF_BIT   = 0;
    localparam int SLED_SZ_LSB   = 1;
    localparam int SLED_ULOW_LSB = 3;

    // Low bits of the interrupt base/control register
    localparam int SLED_IBC_FATAL = 0;
    localparam int SLED_IBC_EV    = 1;
    localparam int SLED_IBC_ERRW  = 5;
    localparam int SLED_NEV       = 4;

    // Event order: param underflow, return underflow, param ovf, ret ovf
    localparam int SLED_EV_PUNF = 0;
    localparam int SLED_EV_RUNF = 1;
    localparam int SLED_EV_POVF = 2;
    localparam int SLED_EV_ROVF = 3;

    typedef enum logic [1:0] {
        SLED_SZ32,
        SLED_SZ64,
        SLED_SZ128,
        SLED_SZ256
    } sled_size_t;

    localparam logic [7:0] SLED_KEEP32  = 8'hE0;
    localparam logic [7:0] SLED_KEEP64  = 8'hC0;
    localparam logic [7:0] SLED_KEEP128 = 8'h80;
    localparam logic [7:0] SLED_KEEP256 = 8'h00;
    localparam logic [7:0] SLED_POS32   = 8'h10;
    localparam logic [7:0] SLED_POS64   = 8'h20;
    localparam logic [7:0] SLED_POS128  = 8'h40;
    localparam logic [7:0] SLED_POS256  = 8'h80;
    localparam logic [7:0] SLED_ONE     = 8'h01;
endpackage

// >>> sled_limit.sv
`timescale 1ns/1ps
module sled_limit
    import sled_pkg::*;
(
    input  wire logic [7:0] ptr,       // Stack pointer byte
    input  wire logic [7:0] ovl,       // Overflow-limit byte
    input  wire logic [7:0] unl,       // Underflow-limit byte
    output logic      [7:0] keep,      // Fixed upper bits of the range
    output logic      [7:0] fatal_lim, // Fatal limit address
    output logic      [7:0] ovf_lim,   // Overflow limit address
    output logic      [7:0] unf_lim,   // Underflow limit address
    output logic      [7:0] ptr_up,    // Next write location
    output logic      [7:0] ptr_dn     // Location after a read
);
    sled_size_t size;
    logic [7:0] pos;
    logic [7:0] low;
    logic [7:0] ulow;
    logic [7:0] pkeep;
    logic       sf;
    logic       top;

    assign size  = sled_size_t'(unl[SLED_SZ_LSB +: 2]);
    assign sf    = unl[SLED_SF_BIT];

    always_comb begin
        unique case (size)
            SLED_SZ32: begin
                keep = SLED_KEEP32;
                pos  = SLED_POS32;
            end
            SLED_SZ64: begin
                keep = SLED_KEEP64;
                pos  = SLED_POS64;
            end
            SLED_SZ128: begin
                keep = SLED_KEEP128;
                pos  = SLED_POS128;
            end
            SLED_SZ256: begin
                keep = SLED_KEEP256;
                pos  = SLED_POS256;
            end
        endcase
    end

    assign low   = ~(keep | pos);
    assign pkeep = ptr & keep;
    assign top   = |(ovl & pos);
    // 32-word substacks have one bit less room below the position bit
    assign ulow  = (size == SLED_SZ32) ? {4'h0, unl[6:SLED_ULOW_LSB]}
                                       : {3'h0, unl[7:SLED_ULOW_LSB]};

    assign fatal_lim = pkeep | ((top && !sf) ? 8'h00 : pos) | low;
    assign ovf_lim   = pkeep | ((top && sf) ? pos : 8'h00)
                     | (ovl & low);
    assign unf_lim   = pkeep | ((top && !sf) ? pos : 8'h00) | ulow;

    // Start flag plays no part in pointer movement
    assign ptr_up = pkeep | ((ptr + SLED_ONE) & ~keep);
    assign ptr_dn = pkeep | ((ptr - SLED_ONE) & ~keep);
endmodule

// >>> sled_top.sv
`timescale 1ns/1ps
module sled_top
    import sled_pkg::*;
(
    input  wire logic        clock,         // 20 MHz core clock
    input  wire logic        rst_n,         // Synchronous reset
    input  wire logic [2:0]  reg_addr,      // Register address
    input  wire logic [15:0] reg_wdata,     // Register write data
    input  wire logic        reg_wr,        // Write strobe
    input  wire logic        reg_rd,        // Read strobe
    output logic      [15:0] reg_rdata,     // Read data, cycle after read
    input  wire logic        param_push,    // Parameter stack write
    input  wire logic        param_pop,     // Parameter stack read
    input  wire logic        ret_push,      // Return stack write
    input  wire logic        ret_pop,       // Return stack read
    output logic      [7:0]  param_ptr,     // Parameter stack pointer
    output logic      [7:0]  ret_ptr,       // Return stack pointer
    output logic             param_ovf_req, // Param overflow request
    output logic             param_unf_req, // Param underflow request
    output logic             ret_ovf_req,   // Return overflow request
    output logic             ret_unf_req,   // Return underflow request
    output logic             fatal_err,     // Either stack fatal
    output logic             irq            // Masked sticky status
);
    logic [7:0]  sp_r      [SLED_NSTK];
    logic [7:0]  sp_nxt    [SLED_NSTK];
    logic [7:0]  keep_w    [SLED_NSTK];
    logic [7:0]  fat_w     [SLED_NSTK];
    logic [7:0]  ovl_w     [SLED_NSTK];
    logic [7:0]  unl_w     [SLED_NSTK];
    logic [7:0]  up_w      [SLED_NSTK];
    logic [7:0]  dn_w      [SLED_NSTK];
    logic [15:0] ovf_lim_r;
    logic [15:0] unf_lim_r;
    logic [10:0] ibc_hi_r;
    logic [1:0]  push_w;
    logic [1:0]  pop_w;
    logic [1:0]  wr_acc;
    logic [1:0]  rd_acc;
    logic [1:0]  hit_ovf;
    logic [1:0]  hit_unf;
    logic [1:0]  hit_fat;
    logic [1:0]  ovf_r;
    logic [1:0]  unf_r;
    logic [1:0]  fat_r;
    logic [1:0]  ovf_nxt;
    logic [1:0]  unf_nxt;
    logic [1:0]  fat_nxt;
    logic [3:0]  stat_r;
    logic [3:0]  stat_nxt;
    logic [3:0]  mask_r;
    logic [3:0]  mask_nxt;
    logic [3:0]  ev_w;
    logic [4:0]  err_w;
    logic [15:0] rdata_nxt;
    logic [15:0] rdata_r;
    logic        fatal_r;
    logic        irq_r;
    logic        ptr_wr;
    logic        ovl_wr;
    logic        unl_wr;
    logic        stat_wr;
    logic        mask_wr;
    logic        ibc_wr;

    assign push_w  = {ret_push, param_push};
    assign pop_w   = {ret_pop, param_pop};
    assign ptr_wr  = reg_wr && (reg_addr == SLED_OFS_PTR);
    assign ovl_wr  = reg_wr && (reg_addr == SLED_OFS_OVF);
    assign unl_wr  = reg_wr && (reg_addr == SLED_OFS_UNF);
    assign ibc_wr  = reg_wr && (reg_addr == SLED_OFS_IBC);
    assign stat_wr = reg_wr && (reg_addr == SLED_OFS_STAT);
    assign mask_wr = reg_wr && (reg_addr == SLED_OFS_MASK);

    genvar i;
    generate
        for (i = 0; i < SLED_NSTK; i = i + 1) begin : g_stk
            // Return stack works from the upper byte of each register
            assign ovl_w[i] = ovf_lim_r[8*i +: 8];
            assign unl_w[i] = unf_lim_r[8*i +: 8];

            sled_limit u_limit (
                .ptr       (sp_r[i]),
                .ovl       (ovl_w[i]),
                .unl       (unl_w[i]),
                .keep      (keep_w[i]),
                .fatal_lim (fat_w[i]),
                .ovf_lim   (),
                .unf_lim   (),
                .ptr_up    (up_w[i]),
                .ptr_dn    (dn_w[i])
            );

            logic [7:0] ovf_lim_w;
            logic [7:0] unf_lim_w;
            sled_limit u_cmp (
                .ptr       (sp_r[i]),
                .ovl       (ovl_w[i]),
                .unl       (unl_w[i]),
                .keep      (),
                .fatal_lim (),
                .ovf_lim   (ovf_lim_w),
                .unf_lim   (unf_lim_w),
                .ptr_up    (),
                .ptr_dn    ()
            );

            // A push and pop together is taken as no access at all
            assign wr_acc[i] = push_w[i] && !pop_w[i];
            assign rd_acc[i] = pop_w[i] && !push_w[i];

            // Writes land at the advanced pointer, reads at the current one
            assign hit_ovf[i] = wr_acc[i] && (up_w[i] == ovf_lim_w);
            assign hit_unf[i] = rd_acc[i] && (sp_r[i] < unf_lim_w);
            assign hit_fat[i] = (wr_acc[i] && (up_w[i] == fat_w[i]))
                             || (rd_acc[i] && (sp_r[i] == fat_w[i]));

            always_comb begin
                if (ptr_wr) begin
                    sp_nxt[i] = reg_wdata[8*i +: 8];
                end else if (wr_acc[i]) begin
                    sp_nxt[i] = up_w[i];
                end else if (rd_acc[i]) begin
                    sp_nxt[i] = dn_w[i];
                end else begin
                    sp_nxt[i] = sp_r[i];
                end
            end

            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    sp_r[i] <= SLED_RST_PTR[8*i +: 8];
                end else begin
                    sp_r[i] <= sp_nxt[i];
                end
            end

            a_wrap_up: assert property (
                @(posedge clock) disable iff (!rst_n)
                (wr_acc[i] && !ptr_wr && ((sp_r[i] | keep_w[i]) == 8'hFF))
                |=> (sp_r[i] == $past(sp_r[i] & keep_w[i])))
            else $error("write did not wrap to lowest location");

            a_wrap_dn: assert property (
                @(posedge clock) disable iff (!rst_n)
                (rd_acc[i] && !ptr_wr && ((sp_r[i] & ~keep_w[i]) == 8'h00))
                |=> (sp_r[i] == $past(sp_r[i] | ~keep_w[i])))
            else $error("read did not wrap to highest location");

            a_ovf_set: assert property (
                @(posedge clock) disable iff (!rst_n)
                (wr_acc[i] && (up_w[i] == ovf_lim_w)) |=> ovf_r[i])
            else $error("overflow not flagged on limit write");

            a_unf_set: assert property (
                @(posedge clock) disable iff (!rst_n)
                (rd_acc[i] && (sp_r[i] < unf_lim_w)) |=> unf_r[i])
            else $error("underflow not flagged on low read");

            // Cleared position bit leaves kept bits and the ones below it
            a_fat_keep: assert property (
                @(posedge clock) disable iff (!rst_n)
                ((fat_w[i] & keep_w[i]) == (sp_r[i] & keep_w[i]))
                && ((fat_w[i] | keep_w[i]) == 8'hFF
                    || (fat_w[i] | keep_w[i])
                       == (keep_w[i] | (~keep_w[i] >> 1))))
            else $error("fatal limit lost kept bits or low ones");
        end
    endgenerate

    // Set wins over the pointer write clear
    assign ovf_nxt = (ovf_r & ~{2{ptr_wr}}) | hit_ovf;
    assign unf_nxt = (unf_r & ~{2{ptr_wr}}) | hit_unf;
    assign fat_nxt = (fat_r & ~{2{ptr_wr}}) | hit_fat;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ovf_r   <= 2'h0;
            unf_r   <= 2'h0;
            fat_r   <= 2'h0;
            fatal_r <= 1'b0;
        end else begin
            ovf_r   <= ovf_nxt;
            unf_r   <= unf_nxt;
            fat_r   <= fat_nxt;
            fatal_r <= |fat_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ovf_lim_r <= SLED_RST_OVF;
            unf_lim_r <= SLED_RST_UNF;
            ibc_hi_r  <= SLED_RST_IBC;
        end else begin
            if (ovl_wr) begin
                ovf_lim_r <= reg_wdata;
            end
            if (unl_wr) begin
                unf_lim_r <= reg_wdata;
            end
            // Only the upper bits store; error flags are read-only
            if (ibc_wr) begin
                ibc_hi_r <= reg_wdata[15:SLED_IBC_ERRW];
            end
        end
    end

    assign ev_w[SLED_EV_PUNF] = hit_unf[0];
    assign ev_w[SLED_EV_RUNF] = hit_unf[1];
    assign ev_w[SLED_EV_POVF] = hit_ovf[0];
    assign ev_w[SLED_EV_ROVF] = hit_ovf[1];

    // Sticky, write one to clear, new event beats the clear
    assign stat_nxt = (stat_r & ~(stat_wr ? reg_wdata[3:0] : 4'h0))
                    | ev_w;
    assign mask_nxt = mask_wr ? reg_wdata[3:0] : mask_r;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stat_r <= 4'h0;
            mask_r <= SLED_RST_MSK;
            irq_r  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            irq_r  <= |(stat_nxt & mask_nxt);
        end
    end

    assign err_w[SLED_IBC_FATAL]              = |fat_r;
    assign err_w[SLED_IBC_EV + SLED_EV_PUNF]  = unf_r[0];
    assign err_w[SLED_IBC_EV + SLED_EV_RUNF]  = unf_r[1];
    assign err_w[SLED_IBC_EV + SLED_EV_POVF]  = ovf_r[0];
    assign err_w[SLED_IBC_EV + SLED_EV_ROVF]  = ovf_r[1];

    always_comb begin
        rdata_nxt = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                SLED_OFS_PTR:  rdata_nxt = {sp_r[1], sp_r[0]};
                SLED_OFS_OVF:  rdata_nxt = ovf_lim_r;
                SLED_OFS_UNF:  rdata_nxt = unf_lim_r;
                SLED_OFS_IBC:  rdata_nxt = {ibc_hi_r, err_w};
                SLED_OFS_STAT: rdata_nxt = {12'h000, stat_r};
                SLED_OFS_MASK: rdata_nxt = {12'h000, mask_r};
                default:       rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata     = rdata_r;
    assign param_ptr     = sp_r[0];
    assign ret_ptr       = sp_r[1];
    assign param_ovf_req = ovf_r[0];
    assign param_unf_req = unf_r[0];
    assign ret_ovf_req   = ovf_r[1];
    assign ret_unf_req   = unf_r[1];
    assign fatal_err     = fatal_r;
    assign irq           = irq_r;

    a_ptr_clear: assert property (
        @(posedge clock) disable iff (!rst_n)
        (ptr_wr && !(|hit_ovf) && !(|hit_unf) && !(|hit_fat))
        |=> (ovf_r == 2'h0 && unf_r == 2'h0 && fat_r == 2'h0))
    else $error("pointer write left an error flag set");

    a_flag_hold: assert property (
        @(posedge clock) disable iff (!rst_n)
        !ptr_wr |=> (((ovf_r & $past(ovf_r)) == $past(ovf_r))
                     && ((unf_r & $past(unf_r)) == $past(unf_r))
                     && ((fat_r & $past(fat_r)) == $past(fat_r))))
    else $error("error flag dropped without pointer write");

    a_ibc_read: assert property (
        @(posedge clock) disable iff (!rst_n)
        (reg_rd && reg_addr == SLED_OFS_IBC)
        |=> (reg_rdata[4:0] == $past(err_w)
             && reg_rdata[0] == $past(|fat_r)))
    else $error("error flags misread in base/control");

    a_irq_level: assert property (
        @(posedge clock) disable iff (!rst_n)
        irq == (|(stat_r & mask_r)))
    else $error("interrupt output disagrees with masked status");

    a_fatal_out: assert property (
        @(posedge clock) disable iff (!rst_n)
        fatal_err == (|fat_r))
    else $error("fatal output disagrees with stack flags");
endmodule

// >>> sled_core_model.sv
`timescale 1ns/1ps
// Core push/pop stage: one register between decode and the stacks,
// so every access reaches the block one cycle after it is requested
module sled_core_model (
    input  wire logic       clock,      // Core clock
    input  wire logic       rst_n,      // Synchronous reset
    input  wire logic [3:0] req,        // Ret pop, ret push, par pop, push
    output logic            param_push, // Parameter stack write
    output logic            param_pop,  // Parameter stack read
    output logic            ret_push,   // Return stack write
    output logic            ret_pop     // Return stack read
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            {ret_pop, ret_push, param_pop, param_push} <= 4'h0;
        end else begin
            {ret_pop, ret_push, param_pop, param_push} <= req;
        end
    end
endmodule

// >>> sled_top_tb.sv
`timescale 1ns/1ps
module sled_top_tb;
    import sled_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [3:0]  req = 4'h0;
    logic [15:0] reg_rdata;
    logic        param_push, param_pop, ret_push, ret_pop;
    logic [7:0]  param_ptr, ret_ptr;
    logic        param_ovf_req, param_unf_req, ret_ovf_req, ret_unf_req;
    logic        fatal_err, irq;
    logic [3:0]  acc;
    int          miscompares = 0;
    int          num_checks = 0;
    int          seed = 3053;
    logic        armed = 1'b0;
    // Mirror of the block, updated from what the block sees at each edge
    logic [15:0] p_r, v_r, u_r, ibc_r, rd_r;
    logic [1:0]  fo_r, fu_r, ff_r;
    logic [3:0]  st_r, mk_r;
    logic        irq_r;

    always #25 clock = ~clock;
    assign acc = {ret_pop, ret_push, param_pop, param_push};

    sled_core_model i_core (.clock(clock), .rst_n(rst_n), .req(req),
        .param_push(param_push), .param_pop(param_pop),
        .ret_push(ret_push), .ret_pop(ret_pop));

    sled_top i_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .param_push(param_push),
        .param_pop(param_pop), .ret_push(ret_push), .ret_pop(ret_pop),
        .param_ptr(param_ptr), .ret_ptr(ret_ptr),
        .param_ovf_req(param_ovf_req), .param_unf_req(param_unf_req),
        .ret_ovf_req(ret_ovf_req), .ret_unf_req(ret_unf_req),
        .fatal_err(fatal_err), .irq(irq));

    always @(posedge clock) begin : mirror
        logic [7:0]  p, v, u, km, k, ps, lo, fl, ol, ul, up, dn;
        logic        top, pu, po, ov, pw;
        logic [3:0]  ev, st, mk;
        logic [15:0] np, rd;
        armed <= 1'b1;
        if (!rst_n) begin
            p_r <= SLED_RST_PTR;
            v_r <= SLED_RST_OVF;
            u_r <= SLED_RST_UNF;
            ibc_r <= 16'h0000;
            {fo_r, fu_r, ff_r} <= 6'h00;
            {st_r, mk_r, irq_r} <= 9'h000;
            rd_r <= 16'h0000;
        end else begin
            pw = reg_wr && reg_addr == SLED_OFS_PTR;
            np = p_r;
            for (int i = 0; i < 2; i++) begin
                p = p_r[8*i+:8];
                v = v_r[8*i+:8];
                u = u_r[8*i+:8];
                km = 8'hE0 << u[2:1];
                k = p & km;
                ps = 8'h10 << u[2:1];
                lo = ps - 8'h01;
                top = |(v & ps);
                fl = k | ((top && !u[0]) ? 8'h00 : ps) | lo;
                ol = k | ((top && u[0]) ? ps : 8'h00) | (v & lo);
                ul = k | ((top && !u[0]) ? ps : 8'h00)
                   | ({3'h0, u[7:3]} & ((u[2:1] == 2'h0) ? 8'h0F : 8'h1F));
                pu = acc[2*i] && !acc[2*i+1];
                po = acc[2*i+1] && !acc[2*i];
                up = k | ((p + 8'h01) & ~km);
                dn = k | ((p - 8'h01) & ~km);
                ov = pu && up == ol;
                ev[i] = po && p < ul;
                ev[i+2] = ov;
                if (pu) np[8*i+:8] = up;
                if (po) np[8*i+:8] = dn;
                fo_r[i] <= (fo_r[i] && !pw) || ov;
                fu_r[i] <= (fu_r[i] && !pw) || ev[i];
                ff_r[i] <= (ff_r[i] && !pw) || (pu && up == fl)
                    || (po && p == fl);
            end
            p_r <= pw ? reg_wdata : np;
            if (reg_wr && reg_addr == SLED_OFS_OVF) v_r <= reg_wdata;
            if (reg_wr && reg_addr == SLED_OFS_UNF) u_r <= reg_wdata;
            if (reg_wr && reg_addr == SLED_OFS_IBC) ibc_r <= reg_wdata;
            st = (reg_wr && reg_addr == SLED_OFS_STAT) ?
                st_r & ~reg_wdata[3:0] : st_r;
            st = st | ev;
            mk = (reg_wr && reg_addr == SLED_OFS_MASK) ? reg_wdata[3:0] : mk_r;
            st_r <= st;
            mk_r <= mk;
            irq_r <= |(st & mk);
            case (reg_addr)
                SLED_OFS_PTR:  rd = p_r;
                SLED_OFS_OVF:  rd = v_r;
                SLED_OFS_UNF:  rd = u_r;
                SLED_OFS_IBC:  rd = {ibc_r[15:5], fo_r[1], fo_r[0], fu_r[1],
                                     fu_r[0], |ff_r};
                SLED_OFS_STAT: rd = {12'h000, st_r};
                SLED_OFS_MASK: rd = {12'h000, mk_r};
                default:       rd = 16'h0000;
            endcase
            rd_r <= reg_rd ? rd : 16'h0000;
        end
    end

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    always @(negedge clock) begin
        if (armed) begin
            chk("param_ptr", {8'h00, param_ptr}, {8'h00, p_r[7:0]});
            chk("ret_ptr", {8'h00, ret_ptr}, {8'h00, p_r[15:8]});
            chk("reg_rdata", reg_rdata, rd_r);
            chk("ovf_req", {14'h0000, ret_ovf_req, param_ovf_req},
                {14'h0000, fo_r});
            chk("unf_req", {14'h0000, ret_unf_req, param_unf_req},
                {14'h0000, fu_r});
            chk("fatal_err", {15'h0000, fatal_err}, {15'h0000, |ff_r});
            chk("irq", {15'h0000, irq}, {15'h0000, irq_r});
        end
    end

    task automatic wrap_up();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic step(input logic w, input logic r, input logic [2:0] a,
                        input logic [15:0] d, input logic [3:0] q);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        req <= q;
        @(posedge clock);
    endtask

    initial begin
        repeat (9000) @(posedge clock);
        miscompares++;
        wrap_up();
    end

    initial begin
        logic [31:0] r;
        logic [15:0] d;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        // Reset values, then the unmapped pair
        for (int a = 0; a < 8; a++) step(1'b0, 1'b1, a[2:0], 16'h0000, 4'h0);
        // Every size code, start flag toggled, wrap both ways
        for (int s = 0; s < 4; s++) begin
            step(1'b1, 1'b0, SLED_OFS_UNF, {2{5'h00, s[1:0], s[0]}}, 4'h0);
            step(1'b1, 1'b0, SLED_OFS_PTR, 16'hFFFF, 4'h5);
            step(1'b0, 1'b0, SLED_OFS_PTR, 16'h0000, 4'h5);
            step(1'b0, 1'b0, SLED_OFS_PTR, 16'h0000, 4'hA);
            step(1'b0, 1'b0, SLED_OFS_PTR, 16'h0000, 4'hA);
            step(1'b0, 1'b0, SLED_OFS_PTR, 16'h0000, 4'hA);
            step(1'b0, 1'b1, SLED_OFS_IBC, 16'h0000, 4'hF);
        end
        step(1'b1, 1'b0, SLED_OFS_MASK, 16'hFFFF, 4'h0);
        step(1'b1, 1'b0, SLED_OFS_IBC, 16'hFFFF, 4'h0);
        step(1'b0, 1'b1, SLED_OFS_IBC, 16'h0000, 4'h0);
        step(1'b1, 1'b0, SLED_OFS_STAT, 16'h000F, 4'h0);
        // Random mix, a second reset half way through
        for (int n = 0; n < 4000; n++) begin
            r = $random(seed);
            d = r[31:16] ^ 16'($random(seed));
            if (n == 2000) rst_n <= 1'b0;
            if (n == 2003) rst_n <= 1'b1;
            step(r[2:0] < 3'h2, r[2:0] == 3'h2, r[10:8], d,
                 (r[2:0] == 3'h2) ? 4'h0 : r[7:4]);
        end
        step(1'b0, 1'b0, 3'h0, 16'h0000, 4'h0);
        step(1'b0, 1'b0, 3'h0, 16'h0000, 4'h0);
        wrap_up();
    end
endmodule
